// *** ddr2_init_and_mode_register_tb_top.sv ***
// self-checking bench for the mode register block
// assumes the controller model in ddrmr_ctrl_model.sv
`timescale 1ns/1ps
module ddr2_init_and_mode_register_tb_top;
  import ddrmr_pkg::*;
  localparam int LOCK = 10;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  ddrmr_cmd_t cmd;
  logic cke;
  logic [13:0] mr;
  ddrmr_mode_t mode;
  logic valid, locked, refp;
  logic [7:0] mask;
  int mismatches = 0;
  int compares = 0;
  logic [13:0] exp_mr = 14'h0000;
  logic exp_valid = 1'b0;
  logic [15:0] lfsr = 16'h989A;
  always #50 mclk_i = ~mclk_i;
  ddrmr_ctrl_model i_ddrmr_ctrl_model(.mclk_i(mclk_i), .cmd_o(cmd), .cke_o(cke));
  ddrmr_mode_reg #(.DLL_LOCK_CLKS(LOCK)) i_ddrmr_mode_reg(.mclk_i(mclk_i), .rst_i(rst_i),
    .cmd_i(cmd), .cke_i(cke), .operating_mode_register_o(mr), .mode_o(mode),
    .mode_valid_o(valid), .dll_locked_o(locked), .pre_bank_mask_o(mask),
    .refresh_pulse_o(refp));
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_mask(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // one command, then every output but the dll lock flag in the one cycle that the pulses stand
  // ----------------------------------------
  task automatic run(input logic [3:0] s, input logic [2:0] ba, input logic [13:0] a);
    logic [7:0] m;
    logic r;
    i_ddrmr_ctrl_model.issue(s, ba, a);
    repeat (2) @(posedge mclk_i);
    #1;
    m = (s == 4'h2 && cke === 1'b1) ? (a[10] ? 8'hFF : 8'h01 << ba) : 8'h00;
    r = (s == 4'h1 && cke === 1'b1);
    if (s == 4'h0 && ba == 3'h0 && cke === 1'b1) begin
      exp_mr = a;
      exp_valid = 1'b1;
    end
    chk("mode_reg", exp_mr, mr);
    chk("fields", {3'h0, exp_mr[2:0], exp_mr[3], exp_mr[6:4], exp_mr[7], exp_mr[11:9]},
      {3'h0, mode});
    chk_bit("valid", exp_valid, valid);
    chk_mask("bank_mask", m, mask);
    chk_bit("refresh", r, refp);
  endtask
  initial begin
    int n;
    repeat (3) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    run(4'h0, 3'h0, 14'h0123);
    i_ddrmr_ctrl_model.power_up();
    run(4'h2, 3'h0, 14'h0400);
    run(4'h0, 3'h2, 14'h0000);
    run(4'h0, 3'h3, 14'h0000);
    run(4'h0, 3'h1, 14'h0000);
    run(4'h0, 3'h0, 14'h0B52);
    chk_bit("dll_reset", 1'b0, locked);
    for (n = 0; n < 40 && locked !== 1'b1; n++) begin
      @(posedge mclk_i);
      #1;
    end
    chk_bit("lock_span", 1'b1, n >= LOCK && n <= LOCK + 1);
    run(4'h2, 3'h0, 14'h0400);
    repeat (2) run(4'h1, 3'h0, 14'h0000);
    run(4'h0, 3'h0, 14'h0A43);
    chk_bit("dll_kept", 1'b1, locked);
    run(4'h0, 3'h1, 14'h0380);
    run(4'h0, 3'h1, 14'h0000);
    // random mode writes, extended writes and single or all-bank precharges
    repeat (8) begin
      lfsr = lfsr_next(lfsr);
      run(lfsr[0] ? 4'h0 : 4'h2, lfsr[3:1], {2'h0, lfsr[15:4]} & 14'h3EFF);
    end
    rst_i = 1'b1;
    @(posedge mclk_i);
    #1;
    chk("rst_mode_reg", 14'h0, mr);
    chk_bit("rst_valid", 1'b0, valid);
    chk_bit("rst_lock", 1'b0, locked);
    rst_i = 1'b0;
    exp_mr = 14'h0000;
    exp_valid = 1'b0;
    run(4'h0, 3'h0, 14'h0032);
    wrap_up();
  end
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
endmodule

// *** ddrmr_cmd_decode.sv ***
// command decoder for the ddr2 command pins
// assumes already-synchronised inputs on the same clock
`timescale 1ns/1ps
`include "ddrmr_params.svh"
module ddrmr_cmd_decode
  import ddrmr_pkg::*;
(
  // command
  input wire ddrmr_cmd_t cmd_i,
  input wire logic cke_i,
  // decoded strobes
  output logic is_mrs_o,
  output logic is_emrs_o,
  output logic is_pre_o,
  output logic pre_all_o,
  output logic is_ref_o
);
  logic mrs_class;

  // all three strobes low with chip select low and cke high is a mode register write
  assign mrs_class = cke_i && !cmd_i.cs_n && !cmd_i.ras_n && !cmd_i.cas_n && !cmd_i.we_n;
  assign is_mrs_o = mrs_class && (cmd_i.ba == `DDRMR_BA_MR);
  assign is_emrs_o = mrs_class && (cmd_i.ba != `DDRMR_BA_MR);
  assign is_pre_o = cke_i && !cmd_i.cs_n && !cmd_i.ras_n && cmd_i.cas_n && !cmd_i.we_n;
  assign pre_all_o = cmd_i.addr[`DDRMR_AP_BIT];
  assign is_ref_o = cke_i && !cmd_i.cs_n && !cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n;
endmodule

// *** ddrmr_ctrl_model.sv ***
// controller-side model driving the ddr2 command and cke pins
// assumes the bench calls its tasks in sequence, one command per call
`timescale 1ns/1ps
module ddrmr_ctrl_model
  import ddrmr_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // command pins
  output ddrmr_cmd_t cmd_o,
  output logic cke_o
);
  // cke low and deselect from time zero; odt is not modelled
  initial begin
    cke_o = 1'b0;
    cmd_o = {4'hF, 3'h0, 14'h0000};
  end
  // s = {cs_n,ras_n,cas_n,we_n}; every field given each time
  task automatic issue(input logic [3:0] s, input logic [2:0] ba, input logic [13:0] a);
    @(posedge mclk_i);
    #1;
    cmd_o = {s, ba, a};
    @(posedge mclk_i);
    #1;
    // deselected lines show the inverse so a stale value cannot pass
    cmd_o = {4'hF, ~ba, ~a};
  endtask
  // wait shortened for sim, then 400 ns of deselect
  task automatic power_up();
    repeat (2) @(posedge mclk_i);
    #1;
    cke_o = 1'b1;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule

// *** ddrmr_mode_reg.sv ***
// ddr2 mode register capture with DLL lock timer
// assumes command pins arrive asynchronous and are double-registered here
`timescale 1ns/1ps
`include "ddrmr_params.svh"
module ddrmr_mode_reg
  import ddrmr_pkg::*;
#(
  parameter int DLL_LOCK_CLKS = `DDRMR_DLL_LOCK_CLKS
)(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // command pins
  input wire ddrmr_cmd_t cmd_i,
  input wire logic cke_i,
  // decoded state
  output logic [`DDRMR_ADDR_W-1:0] operating_mode_register_o,
  output ddrmr_mode_t mode_o,
  output logic mode_valid_o,
  output logic dll_locked_o,
  output logic [7:0] pre_bank_mask_o,
  output logic refresh_pulse_o
);
  localparam int CNT_W = $clog2(DLL_LOCK_CLKS + 1);

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  ddrmr_cmd_t cmd_s1_reg, cmd_s2_reg;
  logic cke_s1_reg, cke_s2_reg;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_s1_reg <= '1;
      cmd_s2_reg <= '1;
      cke_s1_reg <= 1'b0;
      cke_s2_reg <= 1'b0;
    end else begin
      cmd_s1_reg <= cmd_i;
      cmd_s2_reg <= cmd_s1_reg;
      cke_s1_reg <= cke_i;
      cke_s2_reg <= cke_s1_reg;
    end
  end

  logic is_mrs, is_emrs, is_pre, pre_all, is_ref;

  ddrmr_cmd_decode u_dec (
    .cmd_i(cmd_s2_reg),
    .cke_i(cke_s2_reg),
    .is_mrs_o(is_mrs),
    .is_emrs_o(is_emrs),
    .is_pre_o(is_pre),
    .pre_all_o(pre_all),
    .is_ref_o(is_ref)
  );

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [`DDRMR_ADDR_W-1:0] mr_reg, mr_next;
  logic valid_reg, valid_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic locked_reg, locked_next;
  logic [7:0] bank_reg, bank_next;
  logic refp_reg, refp_next;
  ddrmr_mode_t mode_reg, mode_next;

  always_comb begin
    mr_next = mr_reg;
    valid_next = valid_reg;
    cnt_next = cnt_reg;
    locked_next = locked_reg;
    bank_next = 8'h00;
    refp_next = is_ref;
    // only the register is written; the array is never touched here
    if (is_mrs) begin
      mr_next = cmd_s2_reg.addr;
      valid_next = 1'b1;
      if (cmd_s2_reg.addr[`DDRMR_DLLRST_BIT]) begin
        cnt_next = CNT_W'(DLL_LOCK_CLKS);
        locked_next = 1'b0;
      end
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - CNT_W'(1);
      if (cnt_reg == CNT_W'(1)) begin
        locked_next = 1'b1;
      end
    end
    if (is_pre) begin
      if (pre_all) begin
        bank_next = 8'hFF;
      end else begin
        bank_next = 8'h01 << cmd_s2_reg.ba;
      end
    end
    // fields split straight from the stored opcode
    mode_next.burst_len = mr_next[`DDRMR_BL_MSB:`DDRMR_BL_LSB];
    mode_next.burst_ilv = mr_next[`DDRMR_BT_BIT];
    mode_next.cas_lat = mr_next[`DDRMR_CL_MSB:`DDRMR_CL_LSB];
    mode_next.test_mode = mr_next[`DDRMR_TM_BIT];
    mode_next.wr_rec = mr_next[`DDRMR_WR_MSB:`DDRMR_WR_LSB];
  end

  // reset contents are arbitrary zeros; valid stays low until written
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mr_reg <= '0;
      valid_reg <= 1'b0;
      cnt_reg <= '0;
      locked_reg <= 1'b0;
      bank_reg <= 8'h00;
      refp_reg <= 1'b0;
      mode_reg <= '0;
    end else begin
      mr_reg <= mr_next;
      valid_reg <= valid_next;
      cnt_reg <= cnt_next;
      locked_reg <= locked_next;
      bank_reg <= bank_next;
      refp_reg <= refp_next;
      mode_reg <= mode_next;
    end
  end

  assign operating_mode_register_o = mr_reg;
  assign mode_o = mode_reg;
  assign mode_valid_o = valid_reg;
  assign dll_locked_o = locked_reg;
  assign pre_bank_mask_o = bank_reg;
  assign refresh_pulse_o = refp_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // plain signal so the quiet stretch can be negated outside a sequence
  logic dll_rst_cmd;
  assign dll_rst_cmd = is_mrs && cmd_s2_reg.addr[`DDRMR_DLLRST_BIT];

  sequence s_dll_reset;
    dll_rst_cmd;
  endsequence

  sequence s_lock_wait;
    (!dll_rst_cmd) [*8];
  endsequence

  a_mrs_capture: assert property (@(posedge mclk_i) disable iff (rst_i)
    is_mrs |=> (mr_reg == $past(cmd_s2_reg.addr)) && valid_reg)
    else $error("mode write not captured");

  a_emrs_ignored: assert property (@(posedge mclk_i) disable iff (rst_i)
    (is_emrs && !is_mrs) |=> $stable(mr_reg))
    else $error("extended write changed mode register");

  a_dll_unlock: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_dll_reset |=> !dll_locked_o)
    else $error("lock flag kept after dll reset");

  a_dll_lock_time: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_dll_reset ##1 s_lock_wait |-> !dll_locked_o)
    else $error("dll lock flagged too early");

  a_pre_all: assert property (@(posedge mclk_i) disable iff (rst_i)
    (is_pre && pre_all) |=> pre_bank_mask_o == 8'hFF)
    else $error("precharge all not reflected");

  a_pre_one: assert property (@(posedge mclk_i) disable iff (rst_i)
    (is_pre && !pre_all) |=> $onehot(pre_bank_mask_o))
    else $error("single-bank precharge mask wrong");

  a_field_split: assert property (@(posedge mclk_i) disable iff (rst_i)
    is_mrs |=> mode_o.cas_lat == $past(cmd_s2_reg.addr[6:4]))
    else $error("cas latency field mismatch");

  a_wr_field: assert property (@(posedge mclk_i) disable iff (rst_i)
    is_mrs |=> mode_o.wr_rec == $past(cmd_s2_reg.addr[11:9]))
    else $error("write recovery field mismatch");

  a_no_write_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!is_mrs) |=> $stable(mr_reg))
    else $error("mode register changed without write");

  a_cke_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
    !cke_s2_reg |=> $stable(mr_reg) && !refresh_pulse_o && (pre_bank_mask_o == 8'h00))
    else $error("command taken while clock enable low");

  a_valid_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
    mode_valid_o |=> mode_valid_o)
    else $error("mode valid flag dropped");

  a_refresh_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
    is_ref |=> refresh_pulse_o)
    else $error("refresh pulse missing");

  a_lock_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    (dll_locked_o && !dll_rst_cmd) |=> dll_locked_o)
    else $error("lock flag dropped without dll reset");

  a_burst_fields: assert property (@(posedge mclk_i) disable iff (rst_i)
    is_mrs |=> (mode_o.burst_len == $past(cmd_s2_reg.addr[2:0]))
      && (mode_o.burst_ilv == $past(cmd_s2_reg.addr[3])))
    else $error("burst fields mismatch");

  a_test_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
    is_mrs |=> mode_o.test_mode == $past(cmd_s2_reg.addr[7]))
    else $error("test mode bit mismatch");
endmodule

// *** ddrmr_params.svh ***
// constants for the ddr2 mode register and DLL lock timer
// assumes inclusion by ddrmr_pkg and the design modules
`ifndef DDRMR_PARAMS_SVH
`define DDRMR_PARAMS_SVH
`define DDRMR_ADDR_W 14
`define DDRMR_BA_W 3
`define DDRMR_BL_LSB 0
`define DDRMR_BL_MSB 2
`define DDRMR_BT_BIT 3
`define DDRMR_CL_LSB 4
`define DDRMR_CL_MSB 6
`define DDRMR_TM_BIT 7
`define DDRMR_DLLRST_BIT 8
`define DDRMR_WR_LSB 9
`define DDRMR_WR_MSB 11
`define DDRMR_AP_BIT 10
`define DDRMR_BL4_CODE 3'h2
`define DDRMR_BL8_CODE 3'h3
`define DDRMR_BA_MR 3'h0
`define DDRMR_BA_EMR1 3'h1
`define DDRMR_BA_EMR2 3'h2
`define DDRMR_BA_EMR3 3'h3
`define DDRMR_OCD_MASK 14'h0380
`define DDRMR_DLL_LOCK_CLKS 200
`endif

// *** ddrmr_pkg.sv ***
// types for the ddr2 mode register block
// assumes ddrmr_params.svh is on the include path
package ddrmr_pkg;
  `include "ddrmr_params.svh"

  // sampled command bus, active-low strobes as on the pins
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [`DDRMR_BA_W-1:0] ba;
    logic [`DDRMR_ADDR_W-1:0] addr;
  } ddrmr_cmd_t;

  // decoded operating fields of the mode register
  typedef struct packed {
    logic [2:0] burst_len;
    logic burst_ilv;
    logic [2:0] cas_lat;
    logic test_mode;
    logic [2:0] wr_rec;
  } ddrmr_mode_t;
endpackage
